/* speed_clamp_pkg.sv */
// Constants, field layouts and types for the speed command conditioner.
// Assumes one 25 MHz clock and a register map reached over APB.
package speed_clamp_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ADDR_FUNC = 8'h00;
   localparam logic [7:0] ADDR_THRESH = 8'h04;
   localparam logic [7:0] ADDR_POLARITY = 8'h08;
   localparam logic [7:0] ADDR_ACCEL = 8'h0c;
   localparam logic [7:0] ADDR_COMM_CMD = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_HOLD_POS = 8'h18;

   // ****************************************************************
   // Pin function codes, one byte per input pin
   // ****************************************************************
   localparam int NUM_PINS = 4;
   localparam logic [7:0] FN_NONE = 8'h00;
   localparam logic [7:0] FN_RUN_CLOSED = 8'h01;
   localparam logic [7:0] FN_RUN_OPEN = 8'h02;
   localparam logic [7:0] FN_HOLD_CLOSED = 8'h15;
   localparam logic [7:0] FN_HOLD_OPEN = 8'h16;
   localparam logic [7:0] FN_REV_CLOSED = 8'h19;
   localparam logic [7:0] FN_REV_OPEN = 8'h24;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam logic [8:0] PANEL_PER_RPS = 9'h0f0;
   localparam logic [8:0] THRESH_MAX = 9'h1e0;
   localparam logic [8:0] THRESH_RESET = 9'h078;
   localparam logic [15:0] ACCEL_RESET = 16'h0018;
   localparam int COMM_SEL_BIT = 16;
   localparam int ST_HOLD_BIT = 0;
   localparam int ST_RUN_BIT = 1;
   localparam int ST_CCW_BIT = 2;
   localparam int ST_PINS_LSB = 4;

   // ****************************************************************
   // Position loop and timing
   // ****************************************************************
   localparam int HOLD_GAIN_SHIFT = 2;
   localparam logic signed [15:0] HOLD_LIMIT = 16'sh0f00;
   localparam int CLK_MHZ = 25;
   localparam int RAMP_TICK_US = 1000;
   localparam int RAMP_TICK_CYC = RAMP_TICK_US * CLK_MHZ;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef struct packed {
      logic hold_set;
      logic hold_on;
      logic rev_set;
      logic rev_on;
      logic run_set;
      logic run_on;
   } func_state_t;

   typedef enum logic [1:0] {DRV_STOP, DRV_RUN, DRV_HOLD} drive_state_t;

endpackage : speed_clamp_pkg

/* input_sync.sv */
// Two-stage synchroniser for the digital input pins.
// Assumes pins are asynchronous to sys_clk.
module input_sync (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [speed_clamp_pkg::NUM_PINS-1:0] pin_in,
   output logic [speed_clamp_pkg::NUM_PINS-1:0] pin_sync
);

   logic [speed_clamp_pkg::NUM_PINS-1:0] meta_reg;

   // One synchroniser pair per pin
   genvar i;
   generate
      for (i = 0; i < speed_clamp_pkg::NUM_PINS; i++) begin : g_sync
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               meta_reg[i] <= 1'b0;
               pin_sync[i] <= 1'b0;
            end else begin
               meta_reg[i] <= pin_in[i];
               pin_sync[i] <= meta_reg[i];
            end
         end
      end
   endgenerate

endmodule : input_sync

/* speed_ramp.sv */
// Acceleration limiter: steps toward the target once per tick.
// Assumes tick is a one-cycle pulse from the same clock.
module speed_ramp (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic load_zero,
   input wire logic tick,
   input wire logic signed [15:0] target,
   input wire logic [15:0] rate,
   output logic signed [15:0] current
);

   logic signed [16:0] diff;
   logic signed [16:0] step;

   // Distance still to cover
   always_comb begin
      diff = 17'(target) - 17'(current);
      step = $signed({1'b0, rate});
   end

   // Move by one rate step, or land on the target
   always_ff @(posedge sys_clk) begin
      if (rst || load_zero) begin
         current <= 16'sh0000;
      end else if (tick) begin
         if (diff > step) begin
            current <= 16'(17'(current) + step);
         end else if (diff < -step) begin
            current <= 16'(17'(current) - step);
         end else begin
            current <= target;
         end
      end
   end

endmodule : speed_ramp

/* speed_cmd_clamp_direction.sv */
// Speed command conditioner: zero-speed hold, start/stop, direction.
// Assumes APB on sys_clk, command and shaft position from sys_clk logic.
module speed_cmd_clamp_direction #(
   parameter int RAMP_TICK_CYC = speed_clamp_pkg::RAMP_TICK_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [speed_clamp_pkg::NUM_PINS-1:0] din_pins,
   input wire logic signed [15:0] analog_cmd,
   input wire logic signed [31:0] shaft_pos,
   output logic signed [15:0] speed_out,
   output logic dir_ccw,
   output logic motor_run,
   output logic hold_engaged
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [31:0] func_reg;
   logic [8:0] thresh_reg;
   logic pol_reg;
   logic [15:0] accel_reg;
   logic [16:0] comm_reg;
   logic signed [31:0] hold_pos_reg;
   logic [31:0] tick_reg;
   logic [31:0] prdata_reg;
   logic signed [15:0] speed_reg;
   logic dir_reg;
   logic run_reg;
   speed_clamp_pkg::drive_state_t state_reg;
   speed_clamp_pkg::drive_state_t state_next;
   speed_clamp_pkg::func_state_t fs;
   logic [speed_clamp_pkg::NUM_PINS-1:0] pins;
   logic signed [15:0] cmd_sel;
   logic [15:0] cmd_mag;
   logic [15:0] mag_lim;
   logic at_standstill;
   logic hold_request;
   logic run_allowed;
   logic dir_next;
   logic signed [15:0] target_speed;
   logic signed [15:0] ramp_speed;
   logic signed [15:0] corr_speed;
   logic signed [15:0] speed_next;
   logic signed [35:0] pos_err;
   logic ramp_tick;
   logic wr_en;
   logic setup;

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Returns {assigned, active} for one pair of function codes
   function automatic logic [1:0] find_fn(
      input logic [31:0] func,
      input logic [speed_clamp_pkg::NUM_PINS-1:0] lvl,
      input logic [7:0] code_closed,
      input logic [7:0] code_open
   );
      logic set;
      logic on;
      set = 1'b0;
      on = 1'b0;
      for (int p = 0; p < speed_clamp_pkg::NUM_PINS; p++) begin
         if (func[p*8 +: 8] == code_closed) begin
            set = 1'b1;
            on = on | lvl[p];
         end else if (func[p*8 +: 8] == code_open) begin
            set = 1'b1;
            on = on | ~lvl[p];
         end
      end
      return {set, on};
   endfunction : find_fn

   // True for any mapped register offset
   function automatic logic addr_ok(input logic [7:0] a);
      case (a)
         speed_clamp_pkg::ADDR_FUNC,
         speed_clamp_pkg::ADDR_THRESH,
         speed_clamp_pkg::ADDR_POLARITY,
         speed_clamp_pkg::ADDR_ACCEL,
         speed_clamp_pkg::ADDR_COMM_CMD,
         speed_clamp_pkg::ADDR_STATUS,
         speed_clamp_pkg::ADDR_HOLD_POS: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   endfunction : addr_ok

   // ****************************************************************
   // Pin synchronisers and function decode
   // ****************************************************************
   input_sync u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin_in(din_pins),
      .pin_sync(pins)
   );

   // Unassigned functions decode as not set and never active
   always_comb begin
      {fs.hold_set, fs.hold_on} = find_fn(func_reg, pins,
         speed_clamp_pkg::FN_HOLD_CLOSED, speed_clamp_pkg::FN_HOLD_OPEN);
      {fs.rev_set, fs.rev_on} = find_fn(func_reg, pins,
         speed_clamp_pkg::FN_REV_CLOSED, speed_clamp_pkg::FN_REV_OPEN);
      {fs.run_set, fs.run_on} = find_fn(func_reg, pins,
         speed_clamp_pkg::FN_RUN_CLOSED, speed_clamp_pkg::FN_RUN_OPEN);
   end

   // ****************************************************************
   // Command conditioning
   // ****************************************************************
   // Source select, magnitude and standstill compare
   always_comb begin
      cmd_sel = comm_reg[speed_clamp_pkg::COMM_SEL_BIT] ?
         $signed(comm_reg[15:0]) : analog_cmd;
      cmd_mag = cmd_sel[15] ? 16'(16'h0000 - cmd_sel) : cmd_sel;
      mag_lim = cmd_mag[15] ? 16'h7fff : cmd_mag;
      at_standstill = cmd_mag <= {7'h00, thresh_reg};
      hold_request = fs.hold_set & fs.hold_on & at_standstill;
      run_allowed = ~fs.run_set | fs.run_on;
   end

   // Direction from reverse input or command sign, then polarity
   always_comb begin
      if (fs.rev_set) begin
         dir_next = fs.rev_on ^ pol_reg;
      end else begin
         dir_next = cmd_sel[15] ^ pol_reg;
      end
   end

   // Signed target, positive meaning clockwise
   always_comb begin
      if (!run_allowed || cmd_mag == 16'h0000) begin
         target_speed = 16'sh0000;
      end else if (dir_next) begin
         target_speed = -$signed(mag_lim);
      end else begin
         target_speed = $signed(mag_lim);
      end
   end

   // ****************************************************************
   // Drive state machine
   // ****************************************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         speed_clamp_pkg::DRV_STOP: begin
            if (hold_request) begin
               state_next = speed_clamp_pkg::DRV_HOLD;
            end else if (target_speed != 16'sh0000) begin
               state_next = speed_clamp_pkg::DRV_RUN;
            end
         end
         speed_clamp_pkg::DRV_RUN: begin
            if (hold_request) begin
               state_next = speed_clamp_pkg::DRV_HOLD;
            end else if (target_speed == 16'sh0000 && ramp_speed == 16'sh0000) begin
               state_next = speed_clamp_pkg::DRV_STOP;
            end
         end
         speed_clamp_pkg::DRV_HOLD: begin
            if (!hold_request) begin
               state_next = speed_clamp_pkg::DRV_RUN;
            end
         end
         default: state_next = speed_clamp_pkg::DRV_STOP;
      endcase
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= speed_clamp_pkg::DRV_STOP;
      end else begin
         state_reg <= state_next;
      end
   end

   // Shaft position captured on entry to hold
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hold_pos_reg <= 32'sh00000000;
      end else if (state_reg != speed_clamp_pkg::DRV_HOLD &&
                   state_next == speed_clamp_pkg::DRV_HOLD) begin
         hold_pos_reg <= shaft_pos;
      end
   end

   // ****************************************************************
   // Ramp and position loop
   // ****************************************************************
   // Ramp tick divider
   always_ff @(posedge sys_clk) begin
      if (rst || ramp_tick) begin
         tick_reg <= 32'h00000000;
      end else begin
         tick_reg <= tick_reg + 32'h00000001;
      end
   end
   assign ramp_tick = tick_reg >= 32'(RAMP_TICK_CYC - 1);

   // Ramp restarts from zero after hold or a stop input
   speed_ramp u_ramp (
      .sys_clk(sys_clk),
      .rst(rst),
      .load_zero(state_reg == speed_clamp_pkg::DRV_HOLD || !run_allowed),
      .tick(ramp_tick),
      .target(target_speed),
      .rate(accel_reg),
      .current(ramp_speed)
   );

   // Proportional correction toward the captured position
   always_comb begin
      pos_err = (36'(hold_pos_reg) - 36'(shaft_pos)) <<< speed_clamp_pkg::HOLD_GAIN_SHIFT;
      if (pos_err > 36'(speed_clamp_pkg::HOLD_LIMIT)) begin
         corr_speed = speed_clamp_pkg::HOLD_LIMIT;
      end else if (pos_err < -36'(speed_clamp_pkg::HOLD_LIMIT)) begin
         corr_speed = -speed_clamp_pkg::HOLD_LIMIT;
      end else begin
         corr_speed = 16'(pos_err);
      end
   end

   // Speed selection
   always_comb begin
      if (state_reg == speed_clamp_pkg::DRV_HOLD) begin
         speed_next = corr_speed;
      end else if (!run_allowed) begin
         speed_next = 16'sh0000;
      end else begin
         speed_next = ramp_speed;
      end
   end

   // Output registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         speed_reg <= 16'sh0000;
         dir_reg <= 1'b0;
         run_reg <= 1'b0;
      end else begin
         speed_reg <= speed_next;
         dir_reg <= (state_reg == speed_clamp_pkg::DRV_HOLD) ? corr_speed[15] : dir_next;
         run_reg <= speed_next != 16'sh0000;
      end
   end

   assign speed_out = speed_reg;
   assign dir_ccw = dir_reg;
   assign motor_run = run_reg;
   assign hold_engaged = state_reg == speed_clamp_pkg::DRV_HOLD;

   // ****************************************************************
   // APB slave
   // ****************************************************************
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pwrite & addr_ok(paddr);
   assign pready = psel & penable;
   assign pslverr = psel & penable & ~addr_ok(paddr);
   assign prdata = prdata_reg;

   // Writable registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         func_reg <= 32'h00000000;
         thresh_reg <= speed_clamp_pkg::THRESH_RESET;
         pol_reg <= 1'b0;
         accel_reg <= speed_clamp_pkg::ACCEL_RESET;
         comm_reg <= 17'h00000;
      end else if (wr_en) begin
         case (paddr)
            speed_clamp_pkg::ADDR_FUNC: func_reg <= pwdata;
            speed_clamp_pkg::ADDR_THRESH: thresh_reg <= (pwdata[31:9] != 23'h000000 ||
               pwdata[8:0] > speed_clamp_pkg::THRESH_MAX) ? speed_clamp_pkg::THRESH_MAX : pwdata[8:0];
            speed_clamp_pkg::ADDR_POLARITY: pol_reg <= pwdata[0];
            speed_clamp_pkg::ADDR_ACCEL: accel_reg <= pwdata[15:0];
            speed_clamp_pkg::ADDR_COMM_CMD: comm_reg <= pwdata[16:0];
            default: ;
         endcase
      end
   end

   // Read data latched in the setup cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prdata_reg <= 32'h00000000;
      end else if (setup) begin
         case (paddr)
            speed_clamp_pkg::ADDR_FUNC: prdata_reg <= func_reg;
            speed_clamp_pkg::ADDR_THRESH: prdata_reg <= {23'h000000, thresh_reg};
            speed_clamp_pkg::ADDR_POLARITY: prdata_reg <= {31'h00000000, pol_reg};
            speed_clamp_pkg::ADDR_ACCEL: prdata_reg <= {16'h0000, accel_reg};
            speed_clamp_pkg::ADDR_COMM_CMD: prdata_reg <= {15'h0000, comm_reg};
            speed_clamp_pkg::ADDR_STATUS: prdata_reg <= {24'h000000, pins, 1'b0,
               dir_reg, run_reg, hold_engaged};
            speed_clamp_pkg::ADDR_HOLD_POS: prdata_reg <= hold_pos_reg;
            default: prdata_reg <= 32'h00000000;
         endcase
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Hold follows a request by one edge
   a_hold_engage: assert property (hold_request |=> hold_engaged)
      else $error("hold not engaged after request");
   // Inactive or unassigned input never holds
   a_hold_gate: assert property (!(fs.hold_set && fs.hold_on) |=> !hold_engaged)
      else $error("hold engaged with inactive input");
   // Code 22 holds on an open contact
   a_hold_open: assert property (func_reg[7:0] == speed_clamp_pkg::FN_HOLD_OPEN &&
      func_reg[31:8] == 24'h000000 && !pins[0] && at_standstill |=> hold_engaged)
      else $error("open-contact hold failed");
   // Threshold stays within range
   a_thresh_range: assert property (thresh_reg <= speed_clamp_pkg::THRESH_MAX)
      else $error("threshold out of range");
   // Sign ignored in standstill compare
   a_hold_neg_cmd: assert property (fs.hold_set && fs.hold_on && cmd_sel[15] &&
      cmd_mag <= {7'h00, thresh_reg} |=> hold_engaged)
      else $error("negative small command did not hold");
   // Zero command gives zero target
   a_zero_cmd: assert property (cmd_mag == 16'h0000 |-> target_speed == 16'sh0000)
      else $error("zero command with non-zero target");
   // Stop input off forces zero speed
   a_stop_input: assert property (!run_allowed && !hold_request && !hold_engaged
      |=> speed_out == 16'sh0000 && !motor_run)
      else $error("motor turning with stop input off");
   // Direction without reverse input
   a_dir_sign: assert property (!fs.rev_set && !hold_engaged
      |=> dir_ccw == ($past(cmd_sel[15]) ^ $past(pol_reg)))
      else $error("direction not from command sign");
   // Direction with reverse input
   a_dir_reverse: assert property (fs.rev_set && !hold_engaged
      |=> dir_ccw == ($past(fs.rev_on) ^ $past(pol_reg)))
      else $error("direction not from reverse input");
   // Position captured on entry
   a_hold_capture: assert property ($rose(hold_engaged) |-> hold_pos_reg == $past(shaft_pos))
      else $error("hold position not captured");
   // Displaced shaft is driven back
   a_hold_return: assert property (hold_engaged && shaft_pos < hold_pos_reg
      |=> speed_out > 16'sh0000)
      else $error("hold loop not driving back");
   // Leaving hold goes to ramped running
   a_hold_exit: assert property (hold_engaged && !hold_request
      |=> state_reg == speed_clamp_pkg::DRV_RUN && ramp_speed == 16'sh0000)
      else $error("hold exit not to run");

   c_hold_enter: cover property (!hold_engaged ##1 hold_engaged);
   c_hold_leave: cover property (hold_engaged ##1 state_reg == speed_clamp_pkg::DRV_RUN);
   c_reverse_run: cover property (fs.rev_set && fs.rev_on && motor_run);
   c_stop_input: cover property (!run_allowed && cmd_mag != 16'h0000);

endmodule : speed_cmd_clamp_direction

/* host_shaft_model.sv */
// Shaft model: position follows the speed demand plus outside pushes.
// Assumes speed_out and kick arrive on sys_clk.
module host_shaft_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic signed [15:0] speed_out,
   input wire logic signed [31:0] kick,
   output logic signed [31:0] shaft_pos
);
   timeunit 1ns;
   timeprecision 1ns;
   // Positive demand moves the count up; kick is an outside push
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         shaft_pos <= 32'sh0;
      end else begin
         shaft_pos <= shaft_pos + (32'(speed_out) >>> 6) + kick;
      end
   end
endmodule : host_shaft_model

/* speed_cmd_clamp_direction_bench.sv */
// Self-checking bench for the speed command conditioner.
// Assumes the shaft model closes the hold loop on shaft_pos.
module speed_cmd_clamp_direction_bench;
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, dir_ccw, motor_run, hold_engaged, act, ccw, run;
   logic [3:0] din_pins = 4'h0;
   logic signed [15:0] analog_cmd = 16'sh0;
   logic signed [15:0] speed_out;
   logic signed [31:0] shaft_pos, hp;
   logic signed [31:0] kick = 32'sh0;
   logic [32:0] exp_q[$];
   logic [31:0] seed = 32'h0000a22d;
   logic [7:0] codes[4] = '{8'h01, 8'h02, 8'h19, 8'h24};
   int err_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   int m;
   speed_cmd_clamp_direction #(.RAMP_TICK_CYC(4)) dut_u (.sys_clk(sys_clk), .rst(rst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .din_pins(din_pins), .analog_cmd(analog_cmd), .shaft_pos(shaft_pos),
      .speed_out(speed_out), .dir_ccw(dir_ccw), .motor_run(motor_run), .hold_engaged(hold_engaged));
   host_shaft_model shaft_u (.sys_clk(sys_clk), .rst(rst), .speed_out(speed_out), .kick(kick),
      .shaft_pos(shaft_pos));
   // ****************************************************************
   // Helpers
   // ****************************************************************
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic check(string what, logic [32:0] seen, logic [32:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, want, seen);
      end
   endtask : check
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // One APB transfer, held until pready is seen high
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(logic [7:0] a, logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic drive(logic [3:0] p, logic signed [15:0] c);
      @(posedge sys_clk);
      din_pins <= p;
      analog_cmd <= c;
   endtask : drive
   task automatic settle(int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : settle
   task automatic conclude();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : conclude
   // Read results against the oldest note
   always @(posedge sys_clk) begin
      if (psel && penable && pready && !pwrite) begin
         check("prdata", {pslverr, prdata}, exp_q.pop_front());
      end
   end
   // Hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         conclude();
      end
   end
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      rd(speed_clamp_pkg::ADDR_FUNC, 33'h0);
      rd(speed_clamp_pkg::ADDR_THRESH, 33'h078);
      rd(speed_clamp_pkg::ADDR_ACCEL, 33'h018);
      rd(8'h1c, 33'h100000000);
      apb(1'b1, speed_clamp_pkg::ADDR_THRESH, 32'd481);
      rd(speed_clamp_pkg::ADDR_THRESH, 33'h1e0);
      apb(1'b1, speed_clamp_pkg::ADDR_THRESH, 32'd120);
      // No pin functions: sign and polarity decide direction
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, speed_clamp_pkg::ADDR_POLARITY, 32'(i >> 1));
         m = 200 + int'(rnd() % 300);
         ccw = i[1] ^ i[0];
         drive(4'(rnd()), 16'(i[0] ? -m : m));
         settle(250);
         check("dir_ccw", 33'(dir_ccw), 33'(ccw));
         check("speed_out", 33'(speed_out), 33'(ccw ? -m : m));
         check("hold_engaged", 33'(hold_engaged), 33'h0);
      end
      drive(4'h0, 16'sh0);
      settle(250);
      check("motor_run", 33'(motor_run), 33'h0);
      // Start/stop and reverse codes on pin 0 with a negative command
      for (int i = 0; i < 16; i++) begin
         apb(1'b1, speed_clamp_pkg::ADDR_FUNC, 32'(codes[i >> 2]));
         apb(1'b1, speed_clamp_pkg::ADDR_POLARITY, 32'(i[1]));
         m = 200 + int'(rnd() % 300);
         drive(4'(i[0]), 16'(-m));
         settle(250);
         act = codes[i >> 2][0] ? i[0] : !i[0];
         run = (i < 8) ? act : 1'b1;
         ccw = i[1] ^ ((i < 8) ? 1'b1 : act);
         check("motor_run", 33'(motor_run), 33'(run));
         check("dir_ccw", 33'(dir_ccw), 33'(ccw));
         check("speed_out", 33'(speed_out), 33'(run ? (ccw ? -m : m) : 0));
      end
      // Hold codes, contact levels and the threshold boundary
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, speed_clamp_pkg::ADDR_FUNC, 32'(i[2] ? 8'h16 : 8'h15));
         drive(4'(i[0]), i[1] ? 16'sd121 : -16'sd120);
         settle(10);
         act = i[2] ? !i[0] : i[0];
         check("hold_engaged", 33'(hold_engaged), 33'(act && !i[1]));
      end
      // Position lock after an outside push, then leaving hold
      apb(1'b1, speed_clamp_pkg::ADDR_FUNC, 32'h15);
      drive(4'h0, 16'sh0);
      settle(250);
      drive(4'h1, 16'sh0);
      settle(10);
      hp = shaft_pos;
      check("hold_engaged", 33'(hold_engaged), 33'h1);
      rd(speed_clamp_pkg::ADDR_HOLD_POS, {1'b0, hp});
      @(posedge sys_clk);
      kick <= 32'sd200;
      @(posedge sys_clk);
      kick <= 32'sh0;
      settle(2);
      check("speed_sign", 33'(speed_out[15]), 33'h1);
      settle(300);
      check("shaft_back", 33'((hp - shaft_pos) > -16 && (hp - shaft_pos) < 16), 33'h1);
      drive(4'h1, 16'sd600);
      settle(3);
      check("hold_engaged", 33'(hold_engaged), 33'h0);
      check("ramp_start", 33'(speed_out >= -16'sd48 && speed_out <= 16'sd0), 33'h1);
      settle(250);
      check("speed_out", 33'(speed_out), 33'(-600));
      check("dir_ccw", 33'(dir_ccw), 33'h1);
      // Communication command replaces the analog one
      apb(1'b1, speed_clamp_pkg::ADDR_COMM_CMD, 32'({1'b1, -16'sd300}));
      settle(250);
      check("speed_out", 33'(speed_out), 33'(300));
      check("dir_ccw", 33'(dir_ccw), 33'h0);
      rd(speed_clamp_pkg::ADDR_COMM_CMD, 33'({1'b1, -16'sd300}));
      rd(speed_clamp_pkg::ADDR_STATUS, 33'((32'h1 << speed_clamp_pkg::ST_PINS_LSB) |
         (32'h1 << speed_clamp_pkg::ST_RUN_BIT)));
      settle(2);
      conclude();
   end
endmodule : speed_cmd_clamp_direction_bench
